// file: logic/sgdesc_pkg.sv
// Constants shared by the scatter-gather descriptor register block
package sgdesc_pkg;
	localparam int          CH_NUM_DEFAULT     = 4;
	localparam int          ADDR_W             = 12;
	// Per-channel block: 0x000 + ch*0x040
	localparam logic [11:0] CH_BASE            = 12'h0000;
	localparam logic [11:0] CH_STRIDE          = 12'h0040;
	localparam logic [5:0]  OFF_CUR_LOW        = 6'h00;
	localparam logic [5:0]  OFF_CUR_HIGH       = 6'h04;
	localparam logic [5:0]  OFF_TAIL_LOW       = 6'h08;
	localparam logic [5:0]  OFF_TAIL_HIGH      = 6'h0C;
	localparam logic [5:0]  OFF_DROP_COUNT     = 6'h10;
	localparam logic [5:0]  OFF_PROC_COUNT     = 6'h14;
	localparam logic [5:0]  OFF_CH_CTRL        = 6'h18;
	localparam logic [5:0]  OFF_CH_STAT        = 6'h1C;
	localparam logic [11:0] OFF_ENGINE_CTRL    = 12'h0400;
	localparam logic [11:0] OFF_CACHE_USER     = 12'h04B0;
	localparam int          PTR_LSB            = 6;
	localparam int          AWUSER_LSB         = 24;
	localparam int          AWCACHE_LSB        = 16;
	localparam int          ARUSER_LSB         = 8;
	localparam int          ARCACHE_LSB        = 0;
	localparam logic [31:0] CACHE_USER_RESET   = 32'h0003_0003;
	localparam logic [31:0] CACHE_USER_MASK    = 32'h0F0F_0F0F;
	localparam logic [31:0] UNMAPPED_READ      = 32'h0000_0000;
	localparam logic [15:0] COUNT_RESET        = 16'h0000;
	localparam logic [31:0] PTR_RESET          = 32'h0000_0000;
endpackage

// file: logic/sgdesc_chan.sv
// One channel's descriptor pointers, fetch state and packet counters
`timescale 1ns/1ns
module sgdesc_chan
	import sgdesc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        run_i,
	input  wire logic        engine_run_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [5:0]  off_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        cur_update_i,
	input  wire logic [63:0] cur_addr_i,
	input  wire logic        error_i,
	input  wire logic [63:0] error_addr_i,
	input  wire logic        desc_done_i,
	input  wire logic        drop_i,
	input  wire logic        processed_i,
	output logic      [31:0] rdata_o,
	output logic             fetch_req_o,
	output logic             idle_o,
	output logic      [63:0] cur_o,
	output logic      [63:0] tail_o
);
	logic [63:0] cur, next_cur, tail, next_tail;
	logic [15:0] drop_cnt, next_drop_cnt, proc_cnt, next_proc_cnt;
	logic        idle, next_idle, fetch, next_fetch;
	logic        tail_wr;

	always_comb begin
		next_cur      = cur;
		next_tail     = tail;
		next_drop_cnt = drop_cnt;
		next_proc_cnt = proc_cnt;
		next_idle     = idle;
		next_fetch    = 1'b0;
		tail_wr       = wr_i && (off_i == OFF_TAIL_LOW || off_i == OFF_TAIL_HIGH);
		if (wr_i && !run_i) begin
			if (off_i == OFF_CUR_LOW)
				next_cur[31:0] = {wdata_i[31:PTR_LSB], 6'b00_0000};
			if (off_i == OFF_CUR_HIGH)
				next_cur[63:32] = wdata_i;
		end
		if (engine_run_i && cur_update_i)
			next_cur = {cur_addr_i[63:PTR_LSB], 6'b00_0000};
		if (error_i)
			next_cur = {error_addr_i[63:PTR_LSB], 6'b00_0000};
		if (wr_i && off_i == OFF_TAIL_LOW)
			next_tail[31:0] = {wdata_i[31:PTR_LSB], 6'b00_0000};
		if (wr_i && off_i == OFF_TAIL_HIGH)
			next_tail[63:32] = wdata_i;
		// Pause once the descriptor at the tail finishes
		if (desc_done_i && cur == tail)
			next_idle = 1'b1;
		// A tail write while stopped only moves the pause point
		if (tail_wr && run_i) begin
			next_fetch = 1'b1;
			if (idle)
				next_idle = 1'b0;
		end
		if (drop_i)
			next_drop_cnt = drop_cnt + 16'h0001;
		// Read clear wins only over a count already shown
		if (rd_i && off_i == OFF_DROP_COUNT)
			next_drop_cnt = drop_i ? 16'h0001 : COUNT_RESET;
		if (processed_i)
			next_proc_cnt = proc_cnt + 16'h0001;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cur      <= {PTR_RESET, PTR_RESET};
			tail     <= {PTR_RESET, PTR_RESET};
			drop_cnt <= COUNT_RESET;
			proc_cnt <= COUNT_RESET;
			idle     <= 1'b1;
			fetch    <= 1'b0;
		end else begin
			cur      <= next_cur;
			tail     <= next_tail;
			drop_cnt <= next_drop_cnt;
			proc_cnt <= next_proc_cnt;
			idle     <= next_idle;
			fetch    <= next_fetch;
		end
	end

	always_comb begin
		unique case (off_i)
			OFF_CUR_LOW:    rdata_o = cur[31:0];
			OFF_CUR_HIGH:   rdata_o = cur[63:32];
			OFF_TAIL_LOW:   rdata_o = tail[31:0];
			OFF_TAIL_HIGH:  rdata_o = tail[63:32];
			OFF_DROP_COUNT: rdata_o = {16'h0000, drop_cnt};
			OFF_PROC_COUNT: rdata_o = {16'h0000, proc_cnt};
			OFF_CH_STAT:    rdata_o = {31'h0000_0000, idle};
			default:        rdata_o = UNMAPPED_READ;
		endcase
	end

	assign fetch_req_o = fetch;
	assign idle_o      = idle;
	assign cur_o       = cur;
	assign tail_o      = tail;
endmodule // sgdesc_chan

// file: logic/sgdesc_regs.sv
// Multichannel scatter-gather descriptor register block with cache/user controls
`timescale 1ns/1ns
// Summary of operation
// - Current pointer low writable only while channel run control is clear
// - While engine runs, current pointer tracks descriptor in progress
// - On error, current pointer loads the failing descriptor address
// - Upper current pointer exists, reset zero, writable only while run control is clear
// - Tail pointer writable anytime; each write while the channel runs requests a descriptor fetch
// - Fetching stops after the tail descriptor completes; channel paused
// - Running tail write restarts an idle channel, else moves pause point
// - Stopped tail write only moves the pause point, no fetch
// - Upper tail pointer exists, reset zero, its write while running triggers fetch
// - 16-bit drop counter, wraps, cleared by read
// - 16-bit read-only processed counter, reset zero, rolls over
// - Cache/user register drives awuser 27:24 and awcache 19:16
// - Same register drives aruser 11:8 and arcache 3:0
// - Empty queue sets idle; next tail write while running resumes fetching
module sgdesc_regs
	import sgdesc_pkg::*;
#(
	parameter int CH_NUM = CH_NUM_DEFAULT
) (
	input  wire logic                CLK_I,
	input  wire logic                RST_B_I,
	input  wire logic [ADDR_W-1:0]   ADDR_I,
	input  wire logic [31:0]         WDATA_I,
	input  wire logic                WR_I,
	input  wire logic                RD_I,
	output logic      [31:0]         RDATA_O,
	input  wire logic [CH_NUM-1:0]   CUR_UPDATE_I,
	input  wire logic [63:0]         CUR_ADDR_I,
	input  wire logic [CH_NUM-1:0]   ERROR_I,
	input  wire logic [63:0]         ERROR_ADDR_I,
	input  wire logic [CH_NUM-1:0]   DESC_DONE_I,
	input  wire logic [CH_NUM-1:0]   DROP_I,
	input  wire logic [CH_NUM-1:0]   PROCESSED_I,
	output logic      [CH_NUM-1:0]   FETCH_REQ_O,
	output logic      [CH_NUM-1:0]   IDLE_O,
	output logic      [CH_NUM-1:0]   RUN_O,
	output logic                     ENGINE_RUN_O,
	output logic      [CH_NUM*64-1:0] CUR_PTR_O,
	output logic      [CH_NUM*64-1:0] TAIL_PTR_O,
	output logic      [3:0]          SG_AWUSER_O,
	output logic      [3:0]          SG_AWCACHE_O,
	output logic      [3:0]          SG_ARUSER_O,
	output logic      [3:0]          SG_ARCACHE_O
);
	logic [31:0]       cache_user, next_cache_user;
	logic              engine_run, next_engine_run;
	logic [CH_NUM-1:0] run, next_run;
	logic [31:0]       rdata, next_rdata;
	logic [31:0]       ch_rdata [CH_NUM];
	logic [CH_NUM-1:0] ch_hit;
	logic [5:0]        ch_off;

	assign ch_off = ADDR_I[5:0];

	always_comb begin
		next_cache_user = cache_user;
		next_engine_run = engine_run;
		next_run        = run;
		if (WR_I && ADDR_I == OFF_CACHE_USER)
			next_cache_user = WDATA_I & CACHE_USER_MASK;
		if (WR_I && ADDR_I == OFF_ENGINE_CTRL)
			next_engine_run = WDATA_I[0];
		for (int i = 0; i < CH_NUM; i++) begin
			if (WR_I && ch_hit[i] && ch_off == OFF_CH_CTRL)
				next_run[i] = WDATA_I[0];
		end
	end

	always_comb begin
		next_rdata = UNMAPPED_READ;
		if (ADDR_I == OFF_CACHE_USER)
			next_rdata = cache_user;
		else if (ADDR_I == OFF_ENGINE_CTRL)
			next_rdata = {31'h0000_0000, engine_run};
		for (int i = 0; i < CH_NUM; i++) begin
			if (ch_hit[i])
				next_rdata = (ch_off == OFF_CH_CTRL) ? {31'h0000_0000, run[i]} : ch_rdata[i];
		end
		if (!RD_I)
			next_rdata = UNMAPPED_READ;
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			cache_user <= CACHE_USER_RESET;
			engine_run <= 1'b0;
			run        <= '0;
			rdata      <= UNMAPPED_READ;
		end else begin
			cache_user <= next_cache_user;
			engine_run <= next_engine_run;
			run        <= next_run;
			rdata      <= next_rdata;
		end
	end

	for (genvar g = 0; g < CH_NUM; g++) begin : g_chan
		localparam logic [ADDR_W-1:0] BASE = ADDR_W'(CH_BASE + CH_STRIDE * g);
		assign ch_hit[g] = (ADDR_I[ADDR_W-1:6] == BASE[ADDR_W-1:6]);
		sgdesc_chan u_chan (
			.clk_i        (CLK_I),
			.rst_b_i      (RST_B_I),
			.run_i        (run[g]),
			.engine_run_i (engine_run),
			.wr_i         (WR_I && ch_hit[g]),
			.rd_i         (RD_I && ch_hit[g]),
			.off_i        (ch_off),
			.wdata_i      (WDATA_I),
			.cur_update_i (CUR_UPDATE_I[g]),
			.cur_addr_i   (CUR_ADDR_I),
			.error_i      (ERROR_I[g]),
			.error_addr_i (ERROR_ADDR_I),
			.desc_done_i  (DESC_DONE_I[g]),
			.drop_i       (DROP_I[g]),
			.processed_i  (PROCESSED_I[g]),
			.rdata_o      (ch_rdata[g]),
			.fetch_req_o  (FETCH_REQ_O[g]),
			.idle_o       (IDLE_O[g]),
			.cur_o        (CUR_PTR_O[g*64 +: 64]),
			.tail_o       (TAIL_PTR_O[g*64 +: 64])
		);
	end

	assign RDATA_O      = rdata;
	assign RUN_O        = run;
	assign ENGINE_RUN_O = engine_run;
	// Taken live; a change mid-burst would split attributes, hence stop first
	assign SG_AWUSER_O  = cache_user[AWUSER_LSB +: 4];
	assign SG_AWCACHE_O = cache_user[AWCACHE_LSB +: 4];
	assign SG_ARUSER_O  = cache_user[ARUSER_LSB +: 4];
	assign SG_ARCACHE_O = cache_user[ARCACHE_LSB +: 4];
endmodule // sgdesc_regs

// file: test/sgdesc_checker_assertions.sv
// Port checker for the descriptor register block
`timescale 1ns/1ns
module sgdesc_checker
	import sgdesc_pkg::*;
#(
	parameter int CH_NUM = CH_NUM_DEFAULT
) (
	input wire logic [ADDR_W-1:0]    ADDR_I,
	input wire logic                 CLK_I,
	input wire logic                 RST_B_I,
	input wire logic [31:0]          WDATA_I,
	input wire logic                 WR_I,
	input wire logic [CH_NUM-1:0]    ERROR_I,
	input wire logic [63:0]          ERROR_ADDR_I,
	input wire logic [CH_NUM-1:0]    CUR_UPDATE_I,
	input wire logic [CH_NUM-1:0]    RUN_O,
	input wire logic [CH_NUM-1:0]    FETCH_REQ_O,
	input wire logic [CH_NUM*64-1:0] CUR_PTR_O,
	input wire logic [3:0]           SG_AWUSER_O,
	input wire logic [3:0]           SG_AWCACHE_O,
	input wire logic [3:0]           SG_ARUSER_O,
	input wire logic [3:0]           SG_ARCACHE_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);
	chk_tail_fetch: assert property (WR_I && ADDR_I == 12'h008 && RUN_O[0] |=> FETCH_REQ_O[0])
		else $error("no fetch after tail write");
	chk_stopped_quiet: assert property (WR_I && ADDR_I == 12'h008 && !RUN_O[0] |=> !FETCH_REQ_O[0])
		else $error("fetch while channel stopped");
	chk_fetch_cause: assert property (FETCH_REQ_O[0] |-> $past(WR_I) && $past(RUN_O[0])
		&& ($past(ADDR_I) == 12'h008 || $past(ADDR_I) == 12'h00C))
		else $error("fetch without tail write");
	chk_ptr_align: assert property (CUR_PTR_O[5:0] == 6'h00)
		else $error("pointer not aligned");
	chk_aw_fields: assert property (WR_I && ADDR_I == 12'h4B0 |=> SG_AWUSER_O == $past(WDATA_I[27:24])
		&& SG_AWCACHE_O == $past(WDATA_I[19:16]))
		else $error("write side cache or user wrong");
	chk_ar_fields: assert property (WR_I && ADDR_I == 12'h4B0 |=> SG_ARUSER_O == $past(WDATA_I[11:8])
		&& SG_ARCACHE_O == $past(WDATA_I[3:0]))
		else $error("read side cache or user wrong");
	chk_cur_locked: assert property (WR_I && ADDR_I == 12'h000 && RUN_O[0] && !ERROR_I[0]
		&& !CUR_UPDATE_I[0] |=> $stable(CUR_PTR_O[31:0]))
		else $error("current pointer written while running");
	chk_error_load: assert property (ERROR_I[0] |=> CUR_PTR_O[63:0] == {$past(ERROR_ADDR_I[63:6]), 6'h00})
		else $error("error address not loaded");
endmodule // sgdesc_checker
bind sgdesc_regs sgdesc_checker #(.CH_NUM(CH_NUM)) sgdesc_checker_inst (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .ERROR_I(ERROR_I), .ERROR_ADDR_I(ERROR_ADDR_I),
	.CUR_UPDATE_I(CUR_UPDATE_I), .RUN_O(RUN_O), .FETCH_REQ_O(FETCH_REQ_O), .CUR_PTR_O(CUR_PTR_O),
	.SG_AWUSER_O(SG_AWUSER_O), .SG_AWCACHE_O(SG_AWCACHE_O), .SG_ARUSER_O(SG_ARUSER_O),
	.SG_ARCACHE_O(SG_ARCACHE_O));

// file: test/sg_fetch_partner.sv
// Descriptor fetch side model: answers a fetch on channel 0, promptly or slowly
`timescale 1ns/1ns
module sg_fetch_partner #(
	parameter int CH_NUM = 2
) (
	input  wire logic              clk_i,
	input  wire logic              rst_b_i,
	input  wire logic              slow_i,
	input  wire logic [CH_NUM-1:0] fetch_req_i,
	input  wire logic [63:0]       tail_i,
	output logic      [CH_NUM-1:0] cur_update_o,
	output logic      [63:0]       cur_addr_o,
	output logic      [CH_NUM-1:0] done_o
);
	logic [3:0] cnt;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			cnt <= 4'h0;
		else if (fetch_req_i[0])
			cnt <= slow_i ? 4'h9 : 4'h2;
		else if (cnt != 4'h0)
			cnt <= cnt - 4'h1;
	end
	// Jumps to the tail descriptor in one update; address bus is junk when not updating
	assign cur_update_o = {{(CH_NUM-1){1'b0}}, cnt == 4'h2};
	assign cur_addr_o = (cnt == 4'h2) ? tail_i : ~tail_i;
	assign done_o = {{(CH_NUM-1){1'b0}}, cnt == 4'h1};
endmodule // sg_fetch_partner

// file: test/sgdesc_regs_tb.sv
// Self-checking bench for the descriptor register block
`timescale 1ns/1ns
module sgdesc_regs_tb;
	import sgdesc_pkg::*;
	logic              CLK_I, RST_B_I, WR_I, RD_I, slow, ENGINE_RUN_O;
	logic [11:0]       ADDR_I;
	logic [31:0]       WDATA_I, RDATA_O, r;
	logic [63:0]       CUR_ADDR_I, ERROR_ADDR_I, e;
	logic [1:0]        CUR_UPDATE_I, ERROR_I, DESC_DONE_I, DROP_I, PROCESSED_I, FETCH_REQ_O, IDLE_O, RUN_O;
	logic [127:0]      CUR_PTR_O, TAIL_PTR_O;
	logic [3:0]        SG_AWUSER_O, SG_AWCACHE_O, SG_ARUSER_O, SG_ARCACHE_O;
	int                bad_count, n_checks;
	sgdesc_regs #(.CH_NUM(2)) sgdesc_regs_inst (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I),
		.WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .CUR_UPDATE_I(CUR_UPDATE_I),
		.CUR_ADDR_I(CUR_ADDR_I), .ERROR_I(ERROR_I), .ERROR_ADDR_I(ERROR_ADDR_I), .DESC_DONE_I(DESC_DONE_I),
		.DROP_I(DROP_I), .PROCESSED_I(PROCESSED_I), .FETCH_REQ_O(FETCH_REQ_O), .IDLE_O(IDLE_O),
		.RUN_O(RUN_O), .ENGINE_RUN_O(ENGINE_RUN_O), .CUR_PTR_O(CUR_PTR_O), .TAIL_PTR_O(TAIL_PTR_O),
		.SG_AWUSER_O(SG_AWUSER_O), .SG_AWCACHE_O(SG_AWCACHE_O), .SG_ARUSER_O(SG_ARUSER_O),
		.SG_ARCACHE_O(SG_ARCACHE_O));
	sg_fetch_partner #(.CH_NUM(2)) sg_fetch_partner_inst (.clk_i(CLK_I), .rst_b_i(RST_B_I), .slow_i(slow),
		.fetch_req_i(FETCH_REQ_O), .tail_i(TAIL_PTR_O[63:0]), .cur_update_o(CUR_UPDATE_I),
		.cur_addr_o(CUR_ADDR_I), .done_o(DESC_DONE_I));
	function automatic logic [31:0] al(input logic [31:0] d);
		return {d[31:6], 6'h00};
	endfunction
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		n_checks++;
		if (g !== x) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge CLK_I);
		{ADDR_I, WDATA_I, WR_I} <= {a, d, 1'b1};
		@(posedge CLK_I);
		WR_I <= 1'b0;
	endtask
	task automatic rc(input string s, input logic [11:0] a, input logic [31:0] x);
		@(posedge CLK_I);
		{ADDR_I, RD_I} <= {a, 1'b1};
		@(posedge CLK_I);
		RD_I <= 1'b0;
		#1 chk(s, x, RDATA_O);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		CLK_I = 1'b0;
		forever #20 CLK_I = ~CLK_I;
	end
	initial begin
		repeat (80000) @(posedge CLK_I);
		bad_count++;
		end_of_test();
	end
	initial begin
		r = $urandom(32'h78e9);
		{ADDR_I, WDATA_I, WR_I, RD_I, ERROR_I, ERROR_ADDR_I, DROP_I, PROCESSED_I, slow} = '0;
		RST_B_I = 1'b0;
		repeat (8) @(posedge CLK_I);
		RST_B_I <= 1'b1;
		rc("cache reset", 12'h4B0, 32'h0003_0003);
		rc("idle reset", 12'h01C, 32'h0000_0001);
		repeat (3) begin
			r = $urandom;
			wr(12'h4B0, r);
			#1 chk("cache ports", {r[27:24], r[19:16], r[11:8], r[3:0]},
				{SG_AWUSER_O, SG_AWCACHE_O, SG_ARUSER_O, SG_ARCACHE_O});
		end
		$display("test cache done");
		r = $urandom;
		wr(12'h000, r);
		rc("cur low", 12'h000, al(r));
		wr(12'h004, ~r);
		rc("cur high", 12'h004, ~r);
		wr(12'h008, ~r);
		#1 chk("fetch stopped", 32'h0000_0000, FETCH_REQ_O[0]);
		rc("tail low", 12'h008, al(~r));
		wr(12'h048, r);
		#1 chk("ch1 tail port", al(r), TAIL_PTR_O[95:64]);
		chk("ch1 no fetch", 32'h0000_0000, FETCH_REQ_O[1]);
		rc("ch0 tail kept", 12'h008, al(~r));
		$display("test stopped done");
		wr(12'h400, 32'h0000_0001);
		wr(12'h018, 32'h0000_0001);
		#1 chk("run ports", 32'h0000_0017, {ENGINE_RUN_O, RUN_O, IDLE_O});
		wr(12'h000, 32'h0000_0040);
		rc("cur locked", 12'h000, al(r));
		wr(12'h004, 32'h0000_0000);
		rc("cur high locked", 12'h004, ~r);
		for (int i = 0; i < 2; i++) begin
			slow <= i[0];
			wr(12'h008, 32'h0000_1000 + i * 64);
			#1 chk("fetch", 32'h0000_0001, FETCH_REQ_O[0]);
			chk("busy", 32'h0000_0000, IDLE_O[0]);
			repeat (12) @(posedge CLK_I);
			#1 chk("paused", 32'h0000_0001, IDLE_O[0]);
			rc("cur tracks", 12'h000, 32'h0000_1000 + i * 64);
		end
		wr(12'h00C, r);
		#1 chk("fetch high", 32'h0000_0001, FETCH_REQ_O[0]);
		repeat (12) @(posedge CLK_I);
		rc("tail high", 12'h00C, r);
		$display("test running done");
		e = {$urandom, $urandom};
		@(posedge CLK_I);
		{ERROR_ADDR_I, ERROR_I} <= {e, 2'b01};
		@(posedge CLK_I);
		ERROR_I <= 2'b00;
		rc("cur error", 12'h000, al(e[31:0]));
		rc("cur error high", 12'h004, e[63:32]);
		$display("test error done");
		@(posedge CLK_I);
		{DROP_I, PROCESSED_I} <= 4'h5;
		repeat (65537) @(posedge CLK_I);
		{DROP_I, PROCESSED_I} <= 4'h0;
		rc("drop wrap", 12'h010, 32'h0000_0001);
		rc("drop cleared", 12'h010, 32'h0000_0000);
		DROP_I <= 2'b01;
		rc("drop read during drop", 12'h010, 32'h0000_0001);
		DROP_I <= 2'b00;
		rc("drop set wins", 12'h010, 32'h0000_0001);
		wr(12'h014, 32'hFFFF_FFFF);
		rc("processed", 12'h014, 32'h0000_0001);
		rc("processed kept", 12'h014, 32'h0000_0001);
		rc("unmapped", 12'h7F0, 32'h0000_0000);
		$display("test counters done");
		end_of_test();
	end
endmodule // sgdesc_regs_tb
